/* File: logic/ident_chanclass_ie_codec.sv */
// Builder and parser for identification and channel classification elements
// What this block does
// - Each identification field is a type octet, a length octet M and M data octets.
// - Type 0 is vendor identifier, 1 is vendor type, 2 is name string, 3 to 255 reserved.
// - The length octet counts only the data octets that follow it.
// - A vendor identifier field carries the three-octet vendor OUI.
// - OUI octets leave in order from the first to the third.
// - A vendor type field carries the assigner OUI then a three-octet product kind code.
// - A name string field carries two-octet little-endian UTF-16 code units with no count.
// - The classification element starts with its identifier and a length of 1+2N+M.
// - Then comes M, then N channel number and description pairs, then M power limits; the builder still emits one power limit octet when M is 0.
// - Power limits go in descending preference, operating channel first.
// - Channel type codes 000 to 110 are defined and 111 is reserved.
// - Preference 00000 is most preferred and 11111 least preferred.
// - Power limit v from 0 to 99 means v+1 mW and 100 to 255 are reserved.
// - The chosen operating channel is programmed into the MAC and PHY.
// - The identification element is its identifier, its length, then N fields; the builder emits only one field per element.
`timescale 1ns/10ps
`default_nettype none
`include "ie_codec_consts.svh"
module ident_chanclass_ie_codec (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] id_elem_id_i,
  input wire logic [7:0] cls_elem_id_i,
  input wire ie_codec_pkg::ident_t ident_i,
  input wire logic [4:0] name_units_i,
  input wire logic [4:0] ch_count_i,
  input wire logic [4:0] pwr_count_i,
  input wire logic tbl_we_i,
  input wire logic tbl_sel_i,
  input wire logic [4:0] tbl_addr_i,
  input wire logic [15:0] tbl_wdata_i,
  input wire logic build_id_i,
  input wire logic build_cls_i,
  input wire logic tx_ready_i,
  output ie_codec_pkg::octet_t tx_o,
  output logic busy_o,
  input wire ie_codec_pkg::octet_t rx_i,
  output ie_codec_pkg::ident_t rx_ident_o,
  output logic [15:0] rx_name_unit_o,
  output logic rx_name_valid_o,
  output logic [7:0] rx_ch_num_o,
  output ie_codec_pkg::ch_desc_t rx_ch_desc_o,
  output logic rx_ch_valid_o,
  output logic [7:0] rx_pwr_o,
  output logic rx_pwr_valid_o,
  output logic [7:0] oper_ch_o,
  output logic rx_bad_code_o,
  output logic rx_skip_o
);
  import ie_codec_pkg::*;
  typedef enum logic [3:0] {T_IDLE, T_EID, T_LEN, T_FTYPE, T_FLEN, T_FDATA, T_M, T_CH,
    T_PWR} tx_st_t;
  typedef enum logic [2:0] {R_EID, R_LEN, R_FTYPE, R_FLEN, R_FDATA, R_M, R_PAIRS,
    R_PWR} rx_st_t;
  tx_st_t tst_ff;
  rx_st_t rst_ff;
  logic cls_ff, adv, ch_end, rx_is_cls_ff;
  logic [1:0] fsel_ff;
  logic [4:0] raddr;
  logic [7:0] tcnt_ff, ahead_cnt, flen, tdata, pwr_rd;
  logic [7:0] rtype_ff, rcnt_ff, rtot_ff, rm_ff, rbyte_ff;
  logic [15:0] name_rd, ch_rd;
  // Name units live in one table, channel number and description in the other
  ie_table_mem u_name_mem (.clk_i(clk_i), .we_i(tbl_we_i & ~tbl_sel_i), .waddr_i(tbl_addr_i),
    .wdata_i(tbl_wdata_i), .raddr_i(raddr), .rdata_o(name_rd));
  ie_table_mem u_ch_mem (.clk_i(clk_i), .we_i(tbl_we_i & tbl_sel_i), .waddr_i(tbl_addr_i),
    .wdata_i(tbl_wdata_i), .raddr_i(raddr), .rdata_o(ch_rd));
  // Power limits ride in the top byte of the name table slot past the names
  assign pwr_rd = name_rd[15:8];
  assign adv = ~tx_o.valid | tx_ready_i;
  assign ch_end = (tcnt_ff + 8'd1 == {2'b00, ch_count_i, 1'b0});
  always_comb begin
    unique case (fsel_ff)
      2'd0: flen = `OUI_LEN;
      2'd1: flen = `VTYPE_LEN;
      default: flen = {2'b00, name_units_i, 1'b0};
    endcase
  end
  // Read address runs one octet ahead: table data arrive a cycle after it
  always_comb begin
    ahead_cnt = adv ? tcnt_ff + 8'd1 : tcnt_ff;
    unique case (tst_ff)
      T_M: raddr = (ch_count_i != 5'd0) ? 5'h00 : name_units_i;
      T_CH: raddr = (adv && ch_end) ? name_units_i : ahead_cnt[5:1];
      T_PWR: raddr = 5'(ahead_cnt[4:0] + name_units_i);
      T_FDATA: raddr = ahead_cnt[5:1];
      default: raddr = 5'h00;
    endcase
  end
  // Octet to emit in each builder state
  always_comb begin
    tdata = 8'h00;
    unique case (tst_ff)
      T_EID: tdata = cls_ff ? cls_elem_id_i : id_elem_id_i;
      T_LEN: tdata = cls_ff ? 8'(1 + 2 * ch_count_i + pwr_count_i) : 8'(flen + 8'd2);
      T_FTYPE: tdata = {6'h00, fsel_ff};
      T_FLEN: tdata = flen;
      T_FDATA: begin
        if (fsel_ff == 2'd2) begin
          tdata = tcnt_ff[0] ? name_rd[15:8] : name_rd[7:0];
        end else if (tcnt_ff < 8'd3) begin
          tdata = 8'(ident_i.vendor_oui >> (8 * (2 - tcnt_ff[1:0])));
          if (fsel_ff == 2'd1) tdata = 8'(ident_i.assigner_oui >> (8 * (2 - tcnt_ff[1:0])));
        end else begin
          tdata = 8'(ident_i.product_kind_code >> (8 * (5 - tcnt_ff[2:0])));
        end
      end
      T_M: tdata = {3'h0, pwr_count_i};
      T_CH: tdata = tcnt_ff[0] ? ch_rd[7:0] : ch_rd[15:8];
      T_PWR: tdata = pwr_rd;
      default: tdata = 8'h00;
    endcase
  end
  // Builder sequencer; one field per identification element
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tst_ff <= T_IDLE;
      cls_ff <= 1'b0;
      fsel_ff <= 2'd0;
      tcnt_ff <= 8'h00;
      tx_o <= '0;
      busy_o <= 1'b0;
    end else if (adv) begin
      tx_o.valid <= (tst_ff != T_IDLE);
      tx_o.data <= tdata;
      tx_o.last <= 1'b0;
      unique case (tst_ff)
        T_IDLE: begin
          busy_o <= 1'b0;
          tcnt_ff <= 8'h00;
          if (build_cls_i || build_id_i) begin
            cls_ff <= build_cls_i;
            fsel_ff <= (name_units_i != 5'd0) ? 2'd2 : 2'd1;
            tst_ff <= T_EID;
            busy_o <= 1'b1;
          end
        end
        T_EID: tst_ff <= T_LEN;
        T_LEN: tst_ff <= cls_ff ? T_M : T_FTYPE;
        T_FTYPE: tst_ff <= T_FLEN;
        T_FLEN: tst_ff <= T_FDATA;
        T_FDATA: begin
          tcnt_ff <= tcnt_ff + 8'd1;
          if (tcnt_ff + 8'd1 == flen) begin
            tx_o.last <= 1'b1;
            tst_ff <= T_IDLE;
          end
        end
        T_M: tst_ff <= (ch_count_i != 5'd0) ? T_CH : T_PWR;
        T_CH: begin
          tcnt_ff <= tcnt_ff + 8'd1;
          if (tcnt_ff + 8'd1 == {2'b00, ch_count_i, 1'b0}) begin
            tcnt_ff <= 8'h00;
            tst_ff <= T_PWR;
          end
        end
        T_PWR: begin
          tcnt_ff <= tcnt_ff + 8'd1;
          if (tcnt_ff + 8'd1 >= {3'h0, pwr_count_i}) begin
            tx_o.last <= 1'b1;
            tst_ff <= T_IDLE;
          end
        end
        default: tst_ff <= T_IDLE;
      endcase
    end
  end
  // Parser; element kind chosen by identifier
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_ff <= R_EID;
      rx_is_cls_ff <= 1'b0;
      rtype_ff <= 8'h00;
      rcnt_ff <= 8'h00;
      rtot_ff <= 8'h00;
      rm_ff <= 8'h00;
      rbyte_ff <= 8'h00;
      rx_ident_o <= '0;
      rx_name_unit_o <= 16'h0000;
      rx_name_valid_o <= 1'b0;
      rx_ch_num_o <= 8'h00;
      rx_ch_desc_o <= '0;
      rx_ch_valid_o <= 1'b0;
      rx_pwr_o <= 8'h00;
      rx_pwr_valid_o <= 1'b0;
      oper_ch_o <= 8'h00;
      rx_bad_code_o <= 1'b0;
      rx_skip_o <= 1'b0;
    end else begin
      rx_name_valid_o <= 1'b0;
      rx_ch_valid_o <= 1'b0;
      rx_pwr_valid_o <= 1'b0;
      rx_bad_code_o <= 1'b0;
      rx_skip_o <= 1'b0;
      if (rx_i.valid) begin
        rtot_ff <= rtot_ff - 8'd1;
        unique case (rst_ff)
          R_EID: begin
            rx_is_cls_ff <= (rx_i.data == cls_elem_id_i);
            rst_ff <= R_LEN;
          end
          R_LEN: begin
            rtot_ff <= rx_i.data;
            rst_ff <= rx_is_cls_ff ? R_M : R_FTYPE;
          end
          R_FTYPE: begin
            rtype_ff <= rx_i.data;
            rst_ff <= R_FLEN;
          end
          R_FLEN: begin
            rcnt_ff <= 8'h00;
            rm_ff <= rx_i.data;
            rx_skip_o <= (rtype_ff > `ID_TYPE_NAME);
            rst_ff <= (rx_i.data == 8'h00) ? R_FTYPE : R_FDATA;
          end
          R_FDATA: begin
            rcnt_ff <= rcnt_ff + 8'd1;
            if (rtype_ff == `ID_TYPE_VENDOR || rtype_ff == `ID_TYPE_VTYPE) begin
              if (rcnt_ff < 8'd3 && rtype_ff == `ID_TYPE_VENDOR) begin
                rx_ident_o.vendor_oui <= {rx_ident_o.vendor_oui[15:0], rx_i.data};
              end else if (rcnt_ff < 8'd3) begin
                rx_ident_o.assigner_oui <= {rx_ident_o.assigner_oui[15:0], rx_i.data};
              end else if (rcnt_ff < 8'd6) begin
                rx_ident_o.product_kind_code <=
                  {rx_ident_o.product_kind_code[15:0], rx_i.data};
              end
            end else if (rtype_ff == `ID_TYPE_NAME) begin
              if (!rcnt_ff[0]) begin
                rbyte_ff <= rx_i.data;
              end else begin
                rx_name_unit_o <= {rx_i.data, rbyte_ff};
                rx_name_valid_o <= 1'b1;
              end
            end
            if (rcnt_ff + 8'd1 == rm_ff) begin
              rst_ff <= R_FTYPE;
            end
          end
          R_M: begin
            rm_ff <= rx_i.data;
            rcnt_ff <= 8'h00;
            rst_ff <= R_PAIRS;
            if (rtot_ff - 8'd1 == rx_i.data) begin
              rst_ff <= R_PWR;
            end
          end
          R_PAIRS: begin
            rcnt_ff <= rcnt_ff + 8'd1;
            if (!rcnt_ff[0]) begin
              rbyte_ff <= rx_i.data;
            end else begin
              rx_ch_num_o <= rbyte_ff;
              rx_ch_desc_o <= ch_desc_t'(rx_i.data);
              rx_ch_valid_o <= 1'b1;
              rx_bad_code_o <= (rx_i.data[`DESC_TYPE_MSB:`DESC_TYPE_LSB] == `CH_TYPE_RESERVED);
              // Program operating channel; ranking passes through
              if (rx_i.data[`DESC_TYPE_MSB:`DESC_TYPE_LSB] == 3'(CH_OPERATING)) begin
                oper_ch_o <= rbyte_ff;
              end
            end
            if (rtot_ff - 8'd1 == rm_ff) begin
              rcnt_ff <= 8'h00;
              rst_ff <= R_PWR;
            end
          end
          R_PWR: begin
            rx_pwr_o <= rx_i.data;
            rx_pwr_valid_o <= 1'b1;
            rx_bad_code_o <= (rx_i.data > `PWR_LIMIT_MAX);
          end
        endcase
        if (rx_i.last) begin
          rst_ff <= R_EID;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: include/ie_codec_consts.svh */
// Constants for the identification and channel classification element codec
`ifndef IE_CODEC_CONSTS_SVH
`define IE_CODEC_CONSTS_SVH
`define ID_TYPE_VENDOR 8'h00
`define ID_TYPE_VTYPE 8'h01
`define ID_TYPE_NAME 8'h02
`define OUI_LEN 8'h03
`define VTYPE_LEN 8'h06
`define CH_TYPE_RESERVED 3'h7
`define PWR_LIMIT_MAX 8'h63
`define DESC_TYPE_MSB 7
`define DESC_TYPE_LSB 5
`define DESC_PREF_MSB 4
`define DESC_PREF_LSB 0
`define NAME_MAX_UNITS 16
`define CH_MAX 16
`define NAME_IDX_W 5
`define CH_IDX_W 5
`define CLS_ELEM_ID_DEFAULT 8'h00
`endif

/* File: include/ie_codec_pkg.sv */
// Types for the identification and channel classification element codec
package ie_codec_pkg;
  typedef enum logic [2:0] {
    CH_OPERATING, CH_BACKUP, CH_CANDIDATE, CH_PROTECTED_TV,
    CH_WIRELESS_MICROPHONE_PROTECTED, CH_DISALLOWED, CH_UNCLASSIFIED, CH_RESERVED
  } ch_type_t;
  typedef struct packed {
    logic [2:0] kind;
    logic [4:0] pref;
  } ch_desc_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } octet_t;
  typedef struct packed {
    logic [23:0] vendor_oui;
    logic [23:0] assigner_oui;
    logic [23:0] product_kind_code;
  } ident_t;
endpackage

/* File: logic/ie_table_mem.sv */
// Small table memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module ie_table_mem (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [4:0] waddr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [4:0] raddr_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [0:31];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

/* File: tb/codec_chk.sv */
// Assertions on the element codec ports
`timescale 1ns/10ps
`default_nettype none
module codec_chk (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] id_elem_id_i,
  input wire logic [7:0] cls_elem_id_i,
  input wire logic build_id_i,
  input wire logic build_cls_i,
  input wire logic tx_ready_i,
  input wire ie_codec_pkg::octet_t tx_o,
  input wire logic busy_o,
  input wire logic [7:0] rx_ch_num_o,
  input wire ie_codec_pkg::ch_desc_t rx_ch_desc_o,
  input wire logic rx_ch_valid_o,
  input wire logic rx_name_valid_o,
  input wire logic [7:0] rx_pwr_o,
  input wire logic rx_pwr_valid_o,
  input wire logic [7:0] oper_ch_o,
  input wire logic rx_bad_code_o
);
  import ie_codec_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  tx_hold_a: assert property (
    tx_o.valid && !tx_ready_i |=> $stable(tx_o)) else $error("tx octet moved while stalled");
  id_start_a: assert property (
    build_id_i && !build_cls_i && !busy_o && !tx_o.valid |-> ##2 tx_o.valid
    && tx_o.data == id_elem_id_i) else $error("id element start wrong");
  cls_start_a: assert property (
    build_cls_i && !busy_o && !tx_o.valid |-> ##2 tx_o.valid && tx_o.data == cls_elem_id_i)
    else $error("cls element start wrong");
  name_gap_a: assert property (
    rx_name_valid_o |=> !rx_name_valid_o) else $error("name unit not two octets");
  pair_gap_a: assert property (
    rx_ch_valid_o |=> !rx_ch_valid_o) else $error("channel pair not two octets");
  type_flag_a: assert property (
    rx_ch_valid_o && rx_ch_desc_o.kind == 3'h7 |-> rx_bad_code_o) else $error("type 7 not flagged");
  pwr_flag_a: assert property (
    rx_pwr_valid_o |-> rx_bad_code_o == (rx_pwr_o > 8'h63)) else $error("limit flag wrong");
  oper_track_a: assert property (
    rx_ch_valid_o && rx_ch_desc_o.kind == 3'h0 |=> oper_ch_o == $past(rx_ch_num_o))
    else $error("operating channel not kept");
  last_idle_a: assert property (
    tx_o.valid && tx_o.last && tx_ready_i && !build_id_i && !build_cls_i |-> ##[1:2] !busy_o)
    else $error("busy after last");
endmodule
`default_nettype wire

/* File: tb/phy_sink_model.sv */
// Far-side octet sink with optional stalls
`timescale 1ns/10ps
`default_nettype none
module phy_sink_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire ie_codec_pkg::octet_t tx_i,
  input wire logic stall_i,
  output logic ready_o
);
  import ie_codec_pkg::*;
  logic [1:0] cnt_ff;
  logic [15:0] q[$];
  int last_at = -1;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) cnt_ff <= 2'h0;
    else cnt_ff <= cnt_ff + 2'h1;
  end
  assign ready_o = !stall_i || cnt_ff[1];
  always @(posedge clk_i) begin
    if (resetn_i && tx_i.valid && ready_o) begin
      q.push_back({8'h00, tx_i.data});
      if (tx_i.last) last_at = q.size() - 1;
    end
  end
endmodule
`default_nettype wire

/* File: tb/ident_chanclass_ie_codec_tb_top.sv */
// Testbench for the element codec
`timescale 1ns/10ps
`default_nettype none
module ident_chanclass_ie_codec_tb_top;
  import ie_codec_pkg::*;
  logic clk_i = 0, resetn_i = 0, tbl_we_i = 0, tbl_sel_i = 0, build_id_i = 0, build_cls_i = 0;
  logic stall = 0, tx_ready_i, busy_o, rx_name_valid_o, rx_ch_valid_o, rx_pwr_valid_o;
  logic rx_bad_code_o, rx_skip_o;
  logic [7:0] id_elem_id_i = 8'h2a, cls_elem_id_i = 8'h2b, bad_n = 8'h00, skip_n = 8'h00;
  logic [4:0] name_units_i = 5'h00, ch_count_i = 5'h00, pwr_count_i = 5'h00, tbl_addr_i = 5'h00;
  logic [15:0] tbl_wdata_i = 16'h0000, rx_name_unit_o, got_q[$];
  ident_t ident_i = '{24'h1a2b3c, 24'h4d5e6f, 24'h708192}, rx_ident_o;
  octet_t tx_o, rx_i = '0;
  logic [7:0] rx_ch_num_o, rx_pwr_o, oper_ch_o;
  ch_desc_t rx_ch_desc_o;
  int errors = 0, tests_run = 0, cycles = 0;
  always #5 clk_i = ~clk_i;
  ident_chanclass_ie_codec dut_u (.clk_i, .resetn_i, .id_elem_id_i, .cls_elem_id_i, .ident_i,
    .name_units_i, .ch_count_i, .pwr_count_i, .tbl_we_i, .tbl_sel_i, .tbl_addr_i, .tbl_wdata_i,
    .build_id_i, .build_cls_i, .tx_ready_i, .tx_o, .busy_o, .rx_i, .rx_ident_o, .rx_name_unit_o,
    .rx_name_valid_o, .rx_ch_num_o, .rx_ch_desc_o, .rx_ch_valid_o, .rx_pwr_o, .rx_pwr_valid_o,
    .oper_ch_o, .rx_bad_code_o, .rx_skip_o);
  phy_sink_model sink_u (.clk_i, .resetn_i, .tx_i(tx_o), .stall_i(stall), .ready_o(tx_ready_i));
  always @(posedge clk_i) begin
    cycles++;
    if (rx_name_valid_o) got_q.push_back(rx_name_unit_o);
    if (rx_ch_valid_o) got_q.push_back({rx_ch_num_o, rx_ch_desc_o});
    if (rx_pwr_valid_o) got_q.push_back({8'h00, rx_pwr_o});
    if (rx_bad_code_o) bad_n++;
    if (rx_skip_o) skip_n++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [71:0] g, input logic [71:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmpq(input logic [15:0] g[$], input logic [15:0] e[$]);
    chk(72'(g.size()), 72'(e.size()));
    foreach (e[i]) chk(g[i], e[i]);
  endtask
  task automatic wr(input logic s, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    tbl_we_i <= 1'b1;
    tbl_sel_i <= s;
    tbl_addr_i <= a;
    tbl_wdata_i <= d;
    @(posedge clk_i);
    tbl_we_i <= 1'b0;
  endtask
  // Build, retry while busy (must be ignored), then check the stream
  task automatic build(input logic cls, input logic [15:0] e[$]);
    sink_u.q.delete();
    sink_u.last_at = -1;
    @(posedge clk_i);
    if (cls) build_cls_i <= 1'b1;
    else build_id_i <= 1'b1;
    @(posedge clk_i);
    build_cls_i <= 1'b0;
    build_id_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    build_id_i <= 1'b1;
    @(posedge clk_i);
    build_id_i <= 1'b0;
    for (int i = 0; i < 200 && sink_u.last_at < 0; i++) @(posedge clk_i);
    cmpq(sink_u.q, e);
    chk(72'(sink_u.last_at), 72'(e.size() - 1));
  endtask
  task automatic send(input logic [15:0] b[$]);
    foreach (b[i]) begin
      @(posedge clk_i);
      rx_i <= {1'b1, b[i][7:0], i == b.size() - 1};
    end
    @(posedge clk_i);
    rx_i <= '0;
    repeat (3) @(posedge clk_i);
  endtask
  initial begin
    logic [15:0] e[$];
    logic [15:0] x[$];
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    wr(1'b1, 5'h00, 16'h1500);
    wr(1'b1, 5'h01, 16'h2023);
    wr(1'b1, 5'h02, 16'h305f);
    wr(1'b0, 5'h00, 16'h6300);
    wr(1'b0, 5'h01, 16'h0000);
    ch_count_i <= 5'h03;
    pwr_count_i <= 5'h02;
    stall <= 1'b1;
    e = '{8'h2b, 8'h09, 8'h02, 8'h15, 8'h00, 8'h20, 8'h23, 8'h30, 8'h5f, 8'h63, 8'h00};
    build(1'b1, e);
    e = '{8'h2a, 8'h08, 8'h01, 8'h06, 8'h4d, 8'h5e, 8'h6f, 8'h70, 8'h81, 8'h92};
    build(1'b0, e);
    wr(1'b0, 5'h00, 16'h0048);
    wr(1'b0, 5'h01, 16'h20ac);
    name_units_i <= 5'h02;
    stall <= 1'b0;
    e = '{8'h2a, 8'h06, 8'h02, 8'h04, 8'h48, 8'h00, 8'hac, 8'h20};
    build(1'b0, e);
    e = '{8'h2a, 8'h15, 8'h00, 8'h03, 8'h11, 8'h22, 8'h33, 8'h07, 8'h02, 8'haa, 8'hbb,
      8'h01, 8'h06, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88, 8'h99, 8'h02, 8'h02, 8'h41, 8'h00};
    got_q.delete();
    send(e);
    chk(rx_ident_o, 72'h112233445566778899);
    chk(skip_n, 8'h01);
    e = '{16'h0041};
    cmpq(got_q, e);
    e = '{8'h2b, 8'h13, 8'h02};
    for (int i = 0; i < 8; i++) begin
      e.push_back(8'(i + 1));
      e.push_back({3'(i), 5'(i)});
      x.push_back({8'(i + 1), 3'(i), 5'(i)});
    end
    e.push_back(8'h63);
    e.push_back(8'h64);
    x.push_back(16'h0063);
    x.push_back(16'h0064);
    got_q.delete();
    send(e);
    cmpq(got_q, x);
    chk(bad_n, 8'h02);
    chk(oper_ch_o, 8'h01);
    end_of_test();
  end
endmodule
bind ident_chanclass_ie_codec codec_chk chk_u (.clk_i, .resetn_i, .id_elem_id_i, .cls_elem_id_i,
  .build_id_i, .build_cls_i, .tx_ready_i, .tx_o, .busy_o, .rx_ch_num_o, .rx_ch_desc_o,
  .rx_ch_valid_o, .rx_name_valid_o, .rx_pwr_o, .rx_pwr_valid_o, .oper_ch_o, .rx_bad_code_o);
`default_nettype wire
